// ### shared/frame_timer_pkg.sv
// Constants and carrier types for the host status and frame timer bank.
// Assumes an 8-bit processor port with one address line and a 25 MHz clock.
package frame_timer_pkg;

  // Register addresses reached through the internal address pointer
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0d;
  localparam logic [7:0] ADDR_REV_RELOAD_LO = 8'h0e;
  localparam logic [7:0] ADDR_REMAIN_CTRL2 = 8'h0f;

  // Interrupt status field positions
  localparam int ST_DPLUS = 7;
  localparam int ST_DETECT = 6;
  localparam int ST_INSERT = 5;
  localparam int ST_FRAME = 4;
  localparam int ST_DONE_B = 1;
  localparam int ST_DONE_A = 0;
  localparam logic [7:0] ST_STICKY_MASK = 8'h73;

  // Control register two field positions
  localparam int C2_HOST = 7;
  localparam int C2_SWAP = 6;

  // Frame timer layout
  localparam int RELOAD_W = 14;
  localparam int FRAME_NUM_W = 11;
  localparam int REMAIN_LSB = 6;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [13:0] RELOAD_RESET = 14'h0000;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // Timer tick rate derived from the system clock rate
  localparam int SYS_CLK_KHZ = 25000;
  localparam int TICK_KHZ = 12000;
  localparam int TICK_ACC_W = 16;
  localparam logic [15:0] TICK_INC = 16'(TICK_KHZ);
  localparam logic [15:0] TICK_MOD = 16'(SYS_CLK_KHZ);

  // Processor port pins sampled together
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic a0;
    logic [7:0] data;
  } host_port_t;

  // Line levels sampled from the USB pins
  typedef struct packed {
    logic dplus;
    logic dminus;
  } usb_line_t;

endpackage : frame_timer_pkg

// ### rtl/usb_host_status_and_frame_timer.sv
// Interrupt status, revision/reload-low and remaining-time/control-two
// registers with the start-of-frame timer and frame number counter.
// Assumes processor pins and USB line pins are asynchronous to sys_clk;
// event pulses and control register one bits come from sys_clk logic.
`timescale 1ns/1ps

module usb_host_status_and_frame_timer #(
  parameter logic [3:0] REVISION = 4'h7 // Arbitrary revision code
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire frame_timer_pkg::host_port_t port_pins,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire frame_timer_pkg::usb_line_t line_pins,
  input wire logic resume_select,
  input wire logic sof_enable,
  input wire logic resume_event,
  input wire logic done_a_event,
  input wire logic done_b_event,
  output logic frame_tick,
  output logic [10:0] frame_number,
  output logic host_mode,
  output logic polarity_swap,
  output logic extended_en,
  output logic set_b_enable,
  output logic [13:0] frame_count
);
  import frame_timer_pkg::*;

  // Two-flop synchronisers for every pin input
  host_port_t port_meta_q;
  host_port_t port_s_q;
  usb_line_t line_meta_q;
  usb_line_t line_s_q;

  always_ff @(posedge sys_clk) begin
    port_meta_q <= port_pins;
    port_s_q <= port_meta_q;
    line_meta_q <= line_pins;
    line_s_q <= line_meta_q;
  end

  // Strobe decode on the synchronised pins
  wire logic wr_act;
  wire logic rd_act;
  assign wr_act = !port_s_q.cs_n && !port_s_q.wr_n;
  assign rd_act = !port_s_q.cs_n && !port_s_q.rd_n && port_s_q.a0;

  // A write commits when the strobe or select goes away, using the
  // data and A0 seen on the last active cycle, so slow edges are safe.
  logic wr_act_q;
  logic [7:0] wdata_q;
  logic wa0_q;
  wire logic wr_end;
  assign wr_end = wr_act_q && !wr_act;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_act_q <= 1'b0;
      wdata_q <= 8'h00;
      wa0_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        wdata_q <= port_s_q.data;
        wa0_q <= port_s_q.a0;
      end
    end
  end

  // Address pointer written with A0 low, data access with A0 high
  logic [7:0] addr_q;
  wire logic wr_addr;
  wire logic wr_data;
  assign wr_addr = wr_end && !wa0_q;
  assign wr_data = wr_end && wa0_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_q <= ADDR_RESET;
    end else if (wr_addr) begin
      addr_q <= wdata_q;
    end
  end

  // Register write selects
  wire logic wr_status;
  wire logic wr_reload_lo;
  wire logic wr_ctrl2;
  assign wr_status = wr_data && (addr_q == ADDR_INT_STATUS);
  assign wr_reload_lo = wr_data && (addr_q == ADDR_REV_RELOAD_LO);
  assign wr_ctrl2 = wr_data && (addr_q == ADDR_REMAIN_CTRL2);

  // Control two and reload storage
  logic [13:0] reload_q;
  logic host_q;
  logic swap_q;
  logic ext_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reload_q <= RELOAD_RESET;
      host_q <= 1'b0;
      swap_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      if (wr_reload_lo) begin
        reload_q[7:0] <= wdata_q;
      end
      if (wr_ctrl2) begin
        reload_q[13:8] <= wdata_q[5:0];
        host_q <= wdata_q[C2_HOST];
        swap_q <= wdata_q[C2_SWAP];
        ext_q <= 1'b1;
      end
    end
  end

  // 12 MHz tick from 25 MHz by a fractional accumulator; ticks are
  // uneven by one clock but their average rate is exact.
  logic [15:0] tick_acc_q;
  wire logic [15:0] tick_sum;
  wire logic tick;
  assign tick_sum = tick_acc_q + TICK_INC;
  assign tick = tick_sum >= TICK_MOD;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_acc_q <= 16'h0000;
    end else if (tick) begin
      tick_acc_q <= tick_sum - TICK_MOD;
    end else begin
      tick_acc_q <= tick_sum;
    end
  end

  // Down counter, one step per tick; the step that would reach zero
  // reloads instead, so a reload of N gives exactly N ticks per frame
  logic [13:0] count_q;
  logic [10:0] frame_num_q;
  wire logic at_end;
  wire logic expire;
  assign at_end = count_q <= 14'h0001;
  assign expire = sof_enable && tick && at_end;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_q <= RELOAD_RESET;
    end else if (sof_enable && tick) begin
      if (at_end) begin
        count_q <= reload_q;
      end else begin
        count_q <= count_q - 14'h0001;
      end
    end
  end

  // Frame number; a write to control two wins over an expiry
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_num_q <= 11'h000;
    end else if (wr_ctrl2) begin
      frame_num_q <= 11'h000;
    end else if (expire) begin
      frame_num_q <= frame_num_q + 11'h001;
    end
  end

  // Presence and insert/remove detection from SE0 versus idle
  logic se0_q;
  wire logic se0_now;
  wire logic line_change;
  assign se0_now = !line_s_q.dplus && !line_s_q.dminus;
  assign line_change = host_q && (se0_now != se0_q);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      se0_q <= 1'b1;
    end else begin
      se0_q <= se0_now;
    end
  end

  // Sticky events; the set term wins over a write-one clear
  logic [7:0] status_q;
  wire logic [7:0] status_set;
  wire logic [7:0] status_clr;
  wire logic [7:0] status_rd;
  assign status_set = {1'b0,
                       resume_select && resume_event,
                       line_change,
                       expire,
                       2'b00,
                       done_b_event && ext_q,
                       done_a_event};
  assign status_clr = wr_status ? (wdata_q & ST_STICKY_MASK) : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= ((status_q & ~status_clr) | status_set)
                  & ST_STICKY_MASK;
    end
  end

  // Bit 6 is the resume flag or the live not-present indication
  assign status_rd = {line_s_q.dplus,
                      resume_select ? status_q[ST_DETECT] : se0_q,
                      status_q[5:0]};

  // Read data mux and registered read port
  wire logic [7:0] rd_mux;
  logic [7:0] rd_data_q;
  assign rd_mux = (addr_q == ADDR_INT_STATUS) ? status_rd :
                  (addr_q == ADDR_REV_RELOAD_LO) ? {REVISION, 4'h0} :
                  (addr_q == ADDR_REMAIN_CTRL2) ?
                    count_q[13:REMAIN_LSB] :
                  8'h00;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_mux;
    end
  end

  // Outputs
  assign data_out = rd_data_q;
  assign data_oe = rd_act;
  assign frame_tick = expire;
  assign frame_number = frame_num_q;
  assign host_mode = host_q;
  assign polarity_swap = swap_q;
  assign extended_en = ext_q;
  assign set_b_enable = ext_q;
  assign frame_count = count_q;

  // Checks kept beside the logic they guard
  a_dplus_mirror: assert property (@(posedge sys_clk)
    disable iff (reset) addr_q == ADDR_INT_STATUS
    |=> rd_data_q[ST_DPLUS] == $past(line_s_q.dplus))
    else $error("status bit 7 differs from D+");

  a_resume_flag: assert property (@(posedge sys_clk)
    disable iff (reset) resume_select && resume_event |=> status_q[ST_DETECT])
    else $error("resume event not latched");

  a_presence_bit: assert property (@(posedge sys_clk)
    disable iff (reset) !resume_select && addr_q == ADDR_INT_STATUS
    |=> rd_data_q[ST_DETECT] == $past(se0_q))
    else $error("presence bit wrong");

  a_insert_remove: assert property (@(posedge sys_clk)
    disable iff (reset) host_q && $changed(se0_q) |-> status_q[ST_INSERT])
    else $error("insert/remove not flagged");

  a_expiry_flag: assert property (@(posedge sys_clk)
    disable iff (reset) expire
    |=> status_q[ST_FRAME] && frame_count == $past(reload_q))
    else $error("expiry did not flag and reload");

  a_done_b_gate: assert property (@(posedge sys_clk)
    disable iff (reset) !ext_q |=> !status_q[ST_DONE_B])
    else $error("set B done without extended flag");

  a_set_wins: assert property (@(posedge sys_clk)
    disable iff (reset) done_a_event && wr_status && wdata_q[0]
    |=> status_q[ST_DONE_A])
    else $error("clear beat a new done event");

  a_clear_done: assert property (@(posedge sys_clk)
    disable iff (reset) wr_status && wdata_q[0] && !done_a_event
    |=> !status_q[0])
    else $error("write one did not clear");

  a_rev_read: assert property (@(posedge sys_clk)
    disable iff (reset) addr_q == ADDR_REV_RELOAD_LO && $stable(addr_q)
    |=> rd_data_q == {REVISION, 4'h0})
    else $error("revision read wrong");

  a_reserved_zero: assert property (@(posedge sys_clk)
    disable iff (reset) status_q[3:2] == 2'b00)
    else $error("reserved status bits set");

  a_count_down: assert property (@(posedge sys_clk)
    disable iff (reset) sof_enable && tick && count_q > 14'h0001
    |=> count_q == $past(count_q) - 14'h0001)
    else $error("timer did not count down");

  a_frame_clear: assert property (@(posedge sys_clk)
    disable iff (reset) wr_ctrl2 |=> frame_num_q == 11'h000 && ext_q)
    else $error("control write did not clear frame number");

  a_tick_spacing: assert property (@(posedge sys_clk)
    disable iff (reset) tick |=> !tick)
    else $error("tick faster than 12 MHz");

endmodule : usb_host_status_and_frame_timer

// ### tb/usb_device_model.sv
// Behavioural USB peripheral on the host's downstream port.
// Assumes the host holds pull-downs on both data lines.
`timescale 1ns/1ps
module usb_device_model (
  input wire logic attached,
  input wire logic full_speed,
  output frame_timer_pkg::usb_line_t line
);
  import frame_timer_pkg::*;
  // Detached lines fall to SE0; an attached device idles in J
  assign line.dplus = attached & full_speed;
  assign line.dminus = attached & ~full_speed;
endmodule : usb_device_model

// ### tb/usb_host_status_and_frame_timer_test.sv
// Self-checking bench for the host status and frame timer bank.
// Assumes the device model drives the USB lines from bench levels.
`timescale 1ns/1ps
module usb_host_status_and_frame_timer_test;
  import frame_timer_pkg::*;
  localparam logic [3:0] REV = 4'h5; // Arbitrary revision code
  logic sys_clk = 0;
  logic reset = 1;
  host_port_t pins = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
  usb_line_t lines;
  logic res_sel = 0;
  logic sof_en = 0;
  logic [2:0] ev = 3'h0;
  logic attach = 0;
  logic fs = 1;
  logic [7:0] dout;
  logic oe, ftick, host, swap, ext, setb;
  logic [10:0] fnum;
  logic [13:0] fcnt;
  logic [7:0] v;
  int errors = 0;
  int cmp_count = 0;
  int st = 0;
  int n;

  usb_host_status_and_frame_timer #(.REVISION(REV)) DUT (
    .sys_clk(sys_clk), .reset(reset), .port_pins(pins),
    .data_out(dout), .data_oe(oe), .line_pins(lines),
    .resume_select(res_sel), .sof_enable(sof_en),
    .resume_event(ev[1]), .done_a_event(ev[0]), .done_b_event(ev[2]),
    .frame_tick(ftick), .frame_number(fnum), .host_mode(host),
    .polarity_swap(swap), .extended_en(ext), .set_b_enable(setb),
    .frame_count(fcnt)
  );
  usb_device_model peer (.attached(attach), .full_speed(fs), .line(lines));

  // Clock and watchdog; the long frame needs about 25000 cycles
  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask : chk

  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  // Strobe low five clocks, high four, so the synchroniser sees both
  task automatic acc(logic a0, logic is_rd, logic [7:0] d,
                     output logic [7:0] q);
    pins <= '{1'b0, ~is_rd, is_rd, a0, d};
    cyc(4);
    #1;
    q = dout;
    chk("data_oe", 16'(is_rd & a0), 16'(oe));
    @(posedge sys_clk);
    pins <= '{1'b1, 1'b1, 1'b1, a0, d};
    cyc(4);
  endtask : acc

  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, 1'b0, a, q);
    acc(1'b1, 1'b0, d, q);
  endtask : wr

  task automatic rd_chk(logic [7:0] a, logic [7:0] e, string what);
    logic [7:0] q;
    acc(1'b0, 1'b0, a, q);
    acc(1'b1, 1'b1, 8'h00, q);
    chk(what, 16'(e), 16'(q));
  endtask : rd_chk

  task automatic pulse(int i);
    ev <= 3'(1 << i);
    cyc(1);
    ev <= 3'h0;
    cyc(3);
  endtask : pulse

  // Bounded wait, looking 1 ns after each edge where the pulse has
  // settled; returns the edges passed before the tick cycle
  task automatic wait_tick(output int k);
    k = 0;
    #1;
    while (ftick !== 1'b1 && k < 30000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk("frame_tick", 16'h1, 16'(ftick));
  endtask : wait_tick

  // Live D+ and presence come from the lines, the rest from the model
  function automatic logic [7:0] st_exp();
    return 8'(st & 'h33) | {attach & fs, res_sel ? st[6] : ~attach, 6'h00};
  endfunction : st_exp

  initial begin
    v = 8'($urandom(32'hb85e));
    cyc(4);
    reset <= 0;
    cyc(2);
    rd_chk(ADDR_INT_STATUS, st_exp(), "status_reset");
    rd_chk(ADDR_REV_RELOAD_LO, {REV, 4'h0}, "revision");
    pulse(2);
    pulse(0);
    st |= 'h01;
    rd_chk(ADDR_INT_STATUS, st_exp(), "done_a_only");
    v = 8'($urandom);
    wr(ADDR_REMAIN_CTRL2, {1'b1, v[6], 6'h2e});
    chk("ctrl2", 16'({1'b1, v[6], 2'b11, 11'h000}),
        16'({host, swap, ext, setb, fnum}));
    pulse(2);
    st |= 'h02;
    rd_chk(ADDR_INT_STATUS, st_exp(), "done_b");
    wr(ADDR_INT_STATUS, {6'h00, v[3:2]} << 2 | 8'h01);
    st &= ~'h01;
    rd_chk(ADDR_INT_STATUS, st_exp(), "clear_one");
    attach <= 1;
    fs <= v[5];
    cyc(8);
    st |= 'h20;
    rd_chk(ADDR_INT_STATUS, st_exp(), "attach");
    res_sel <= 1;
    pulse(1);
    st |= 'h40;
    rd_chk(ADDR_INT_STATUS, st_exp(), "resume");
    // A done event on the very commit cycle of the clear must survive
    fork
      wr(ADDR_INT_STATUS, 8'hff);
      begin
        cyc(16);
        ev <= 3'h1;
        cyc(1);
        ev <= 3'h0;
      end
    join
    st = 'h01;
    res_sel <= 0;
    rd_chk(ADDR_INT_STATUS, st_exp(), "clear_all");
    // One full 1 ms frame: 12000 ticks at 12 of every 25 clocks
    wr(ADDR_REV_RELOAD_LO, 8'he0);
    wr(ADDR_REMAIN_CTRL2, 8'hae);
    sof_en <= 1;
    wait_tick(n);
    cyc(1);
    #1;
    chk("reload", 16'h2ee0, 16'(fcnt));
    wait_tick(n);
    chk("period", 16'(12000 * SYS_CLK_KHZ / TICK_KHZ), 16'(n + 1));
    cyc(1);
    #1;
    chk("frame_number", 16'h2, 16'(fnum));
    cyc(2000);
    sof_en <= 0;
    rd_chk(ADDR_REMAIN_CTRL2, 8'hac, "remaining");
    st |= 'h10;
    rd_chk(ADDR_INT_STATUS, st_exp(), "frame_flag");
    chk("frozen", 16'h2b20, 16'(fcnt));
    report_and_stop();
  end
endmodule : usb_host_status_and_frame_timer_test
